// file: cpm_pkg.sv
// Types shared by the clock and power configuration block.
// Assumes cpm_regs.svh sits beside it.
`include "cpm_regs.svh"
package cpm_pkg;
  // ========================================================================
  // Configuration word layout
  typedef struct packed {
    logic [7:0] unused_hi;
    logic       mains_base_freq_select;
    logic       timestamp_update_mode;
    logic [5:0] low_battery_threshold;
    logic [2:0] supply_measure_rate;
    logic       general_handling_clock_mode;
    logic [2:0] fast_clock_calib_rate;
    logic       fast_clock_freq_select;
    logic [2:0] fast_clock_hold_timeout;
    logic [2:0] fast_clock_settle_time;
    logic [1:0] unused_lo;
  } cpm_cfg_t;
  // Status word layout
  typedef struct packed {
    logic [25:0] zero;
    logic        gph_pend;
    logic        calib_pend;
    logic        hold_live;
    logic        eff_sel;
    logic        ready;
    logic        on;
  } cpm_stat_t;
  // Fast clock states
  typedef enum logic [1:0] {
    CPM_FC_OFF    = 2'b00,
    CPM_FC_SETTLE = 2'b01,
    CPM_FC_ON     = 2'b10
  } cpm_fc_state_t;
endpackage

// file: cpm_rate_div.sv
// Trigger divider: passes every Nth measure cycle trigger, N from a code.
// Assumes trig is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`include "cpm_regs.svh"
module cpm_rate_div
  import cpm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       trig,
  input  wire logic [2:0] code,
  output logic            go
);
  logic [6:0] cnt;
  logic [6:0] div;

  // Code to divisor; code 0 disables
  always_comb begin
    case (code)
      3'h1:    div = `CPM_DIV1;
      3'h2:    div = `CPM_DIV2;
      3'h3:    div = `CPM_DIV3;
      3'h4:    div = `CPM_DIV4;
      3'h5:    div = `CPM_DIV5;
      3'h6:    div = `CPM_DIV6;
      3'h7:    div = `CPM_DIV7;
      default: div = 7'h00;
    endcase
  end

  // Count triggers; >= copes with a code lowered mid-count
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 7'h00;
      go  <= 1'b0;
    end else if (div == 7'h00) begin
      cnt <= 7'h00;
      go  <= 1'b0;
    end else if (trig) begin
      if (cnt + 7'h01 >= div) begin
        cnt <= 7'h00;
        go  <= 1'b1;
      end else begin
        cnt <= cnt + 7'h01;
        go  <= 1'b0;
      end
    end else begin
      go <= 1'b0;
    end
  end

  // ========================================================================
  // Checks
  div_cause_a: assert property (@(posedge clk) disable iff (rst)
    go |-> $past(trig) && $past(code) != 3'h0) else $error("divider pulse without cause");
  every_trig_a: assert property (@(posedge clk) disable iff (rst)
    trig && code == 3'h1 && cnt == 7'h00 |=> go) else $error("code 1 missed a trigger");
  div_cover_c: cover property (@(posedge clk) disable iff (rst) go);
endmodule

// file: cpm_regs.svh
// Register map, field layout and timing figures of the clock and power block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH
// ==========================================================================
// Register byte offsets
`define CPM_OFS_CFG     4'h0
`define CPM_OFS_STAT    4'h4
`define CPM_OFS_CTRL    4'h8
// Reset value and writable bits of the configuration word
`define CPM_CFG_RST     32'h0000_0138
`define CPM_CFG_WMASK   32'h00FF_FFFC
// Control word: period field width, timestamp trigger bit
`define CPM_PER_W       13
`define CPM_CTRL_TS     31
`define CPM_CTRL_TS_BE  3
// ==========================================================================
// Clock and fixed times
`define CPM_CLK_MHZ     10
`define CPM_CLK_PS      100000
`define CPM_MS_PS       1000000000
`define CPM_LP_TICK_PS  976562500
`define CPM_FRAC        64
`define CPM_MS_PER_S    1000
`define CPM_T50_US      20000
`define CPM_T60_US      16660
// Settling times in microseconds
`define CPM_ST0_US      74
`define CPM_ST1_US      104
`define CPM_ST2_US      135
`define CPM_ST3_US      196
`define CPM_ST4_US      257
`define CPM_ST5_US      379
`define CPM_ST6_US      502
`define CPM_ST7_US      5000
// Hold timeouts in milliseconds
`define CPM_HT0_MS      7'h0A
`define CPM_HT1_MS      7'h14
`define CPM_HT2_MS      7'h1E
`define CPM_HT3_MS      7'h28
`define CPM_HT4_MS      7'h3C
`define CPM_HT5_MS      7'h50
`define CPM_HT7_MS      7'h78
// Trigger divisors for rate codes 1 to 7
`define CPM_DIV1        7'h01
`define CPM_DIV2        7'h02
`define CPM_DIV3        7'h05
`define CPM_DIV4        7'h0A
`define CPM_DIV5        7'h14
`define CPM_DIV6        7'h32
`define CPM_DIV7        7'h64
`endif

// file: cpm_top.sv
// Clock and power management configuration: register file on Avalon-MM,
// measure rate generator, rate dividers, fast clock start/hold control.
// Assumes mode, request and link inputs come from logic on SYS_CLK.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "cpm_regs.svh"
module cpm_top
  import cpm_pkg::*;
#(
  parameter int MS_CYCLES       = `CPM_MS_PS / `CPM_CLK_PS,
  parameter int LP_TICK_UNITS   =
    int'(longint'(`CPM_LP_TICK_PS) * `CPM_FRAC / `CPM_CLK_PS),
  parameter int SETTLE_LONG_CYC = `CPM_ST7_US * `CPM_CLK_MHZ
)(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        FLOW_MODE,
  input  wire logic        RC_FAST_CLK_SEL,
  input  wire logic        LP_MODE,
  input  wire logic        SERIAL_HIGH_RATE_MODE,
  input  wire logic        FAST_CLK_REQ,
  input  wire logic        GPH_REQ,
  output logic             MAINS_60HZ,
  output logic [14:0]      MAINS_PERIOD_US,
  output logic             TS_UPDATE,
  output logic [5:0]       LOW_BAT_TH,
  output logic             MEASURE_TRIG,
  output logic             SUPPLY_MEAS_GO,
  output logic             CALIB_GO,
  output logic             GPH_GO,
  output logic             FAST_CLK_EN,
  output logic             FAST_CLK_READY,
  output logic             FAST_CLK_8MHZ
);
  localparam logic [19:0] MS_UNITS = 20'(MS_CYCLES * `CPM_FRAC);
  localparam logic [19:0] LP_UNITS = 20'(LP_TICK_UNITS);
  localparam logic [19:0] FRAC     = 20'(`CPM_FRAC);
  localparam logic [15:0] MS_LAST  = 16'(MS_CYCLES - 1);
  localparam logic [9:0]  S_LAST   = 10'(`CPM_MS_PER_S - 1);

  cpm_cfg_t            cfg;
  cpm_stat_t           stat;
  cpm_fc_state_t       fc_state;
  cpm_fc_state_t       next_fc;
  logic [`CPM_PER_W-1:0] period;
  logic [`CPM_PER_W-1:0] per_cnt;
  logic [19:0]         acc;
  logic [20:0]         acc_sum;
  logic                base_tick;
  logic [15:0]         ms_cnt;
  logic                ms_tick;
  logic [9:0]          sec_cnt;
  logic                ts_sw;
  logic                wr_en;
  logic [31:0]         be_mask;
  logic [31:0]         rd_mux;
  logic [15:0]         settle_cnt;
  logic [15:0]         settle_len;
  logic [15:0]         chk_cnt;
  logic [6:0]          hold_cnt;
  logic                hold_live;
  logic                calib_div;
  logic                calib_pend;
  logic                gph_pend;
  logic                fc_req;
  logic                eff_sel;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  // ========================================================================
  // Lookup tables
  // Settling code to clock cycles
  function automatic logic [15:0] settle_cyc(input logic [2:0] code);
    case (code)
      3'h0:    settle_cyc = 16'(`CPM_ST0_US * `CPM_CLK_MHZ);
      3'h1:    settle_cyc = 16'(`CPM_ST1_US * `CPM_CLK_MHZ);
      3'h2:    settle_cyc = 16'(`CPM_ST2_US * `CPM_CLK_MHZ);
      3'h3:    settle_cyc = 16'(`CPM_ST3_US * `CPM_CLK_MHZ);
      3'h4:    settle_cyc = 16'(`CPM_ST4_US * `CPM_CLK_MHZ);
      3'h5:    settle_cyc = 16'(`CPM_ST5_US * `CPM_CLK_MHZ);
      3'h6:    settle_cyc = 16'(`CPM_ST6_US * `CPM_CLK_MHZ);
      default: settle_cyc = 16'(SETTLE_LONG_CYC);
    endcase
  endfunction

  // Hold code to milliseconds; unlisted 110 treated as the longest
  function automatic logic [6:0] hold_ms(input logic [2:0] code);
    case (code)
      3'h0:    hold_ms = `CPM_HT0_MS;
      3'h1:    hold_ms = `CPM_HT1_MS;
      3'h2:    hold_ms = `CPM_HT2_MS;
      3'h3:    hold_ms = `CPM_HT3_MS;
      3'h4:    hold_ms = `CPM_HT4_MS;
      3'h5:    hold_ms = `CPM_HT5_MS;
      default: hold_ms = `CPM_HT7_MS;
    endcase
  endfunction

  // ========================================================================
  // Avalon-MM slave
  // One wait cycle per access; the write lands when waitrequest is low
  assign wr_en = AVS_WRITE & ~AVS_WAITREQUEST;
  assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (AVS_ADDRESS)
      `CPM_OFS_CFG:  rd_mux = cfg;
      `CPM_OFS_STAT: rd_mux = stat;
      `CPM_OFS_CTRL: rd_mux = 32'(period);
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stand in the cycle waitrequest is low
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ & AVS_WAITREQUEST) begin
      AVS_READDATA <= rd_mux;
    end else begin
      AVS_READDATA <= 32'h0000_0000;
    end
  end

  // Configuration word; unused bits never stored so they read zero
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cfg <= `CPM_CFG_RST;
    end else if (wr_en && AVS_ADDRESS == `CPM_OFS_CFG) begin
      cfg <= (cfg & ~(be_mask & `CPM_CFG_WMASK)) |
             (AVS_WRITEDATA & be_mask & `CPM_CFG_WMASK);
    end
  end

  // Control word: period count and self-clearing timestamp trigger
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      period <= '0;
      ts_sw  <= 1'b0;
    end else begin
      ts_sw <= wr_en && AVS_ADDRESS == `CPM_OFS_CTRL &&
               AVS_BYTEENABLE[`CPM_CTRL_TS_BE] && AVS_WRITEDATA[`CPM_CTRL_TS];
      if (wr_en && AVS_ADDRESS == `CPM_OFS_CTRL) begin
        if (AVS_BYTEENABLE[0]) period[7:0] <= AVS_WRITEDATA[7:0];
        if (AVS_BYTEENABLE[1]) period[`CPM_PER_W-1:8] <= AVS_WRITEDATA[`CPM_PER_W-1:8];
      end
    end
  end

  // Status view of the block's own state
  assign stat = '{zero: '0, gph_pend: gph_pend, calib_pend: calib_pend,
                  hold_live: hold_live, eff_sel: eff_sel,
                  ready: FAST_CLK_READY, on: FAST_CLK_EN};

  // ========================================================================
  // Time bases
  // Millisecond tick for hold timeout and seconds
  assign ms_tick = (ms_cnt == MS_LAST);
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ms_cnt  <= 16'h0000;
      sec_cnt <= 10'h000;
    end else begin
      ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
      if (ms_tick) begin
        sec_cnt <= (sec_cnt == S_LAST) ? 10'h000 : sec_cnt + 10'h001;
      end
    end
  end

  // Fractional accumulator: low-power tick is not a whole cycle count
  assign acc_sum = {1'b0, acc} + {1'b0, FRAC};
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      acc       <= 20'h00000;
      base_tick <= 1'b0;
    end else if (acc_sum >= {1'b0, LP_MODE ? LP_UNITS : MS_UNITS}) begin
      acc       <= 20'(acc_sum - {1'b0, LP_MODE ? LP_UNITS : MS_UNITS});
      base_tick <= 1'b1;
    end else begin
      acc       <= acc_sum[19:0];
      base_tick <= 1'b0;
    end
  end

  // Measure rate generator; zero period stops it
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      per_cnt      <= '0;
      MEASURE_TRIG <= 1'b0;
    end else if (period == '0) begin
      per_cnt      <= '0;
      MEASURE_TRIG <= 1'b0;
    end else if (base_tick) begin
      if (per_cnt + 1'b1 >= period) begin
        per_cnt      <= '0;
        MEASURE_TRIG <= 1'b1;
      end else begin
        per_cnt      <= per_cnt + 1'b1;
        MEASURE_TRIG <= 1'b0;
      end
    end else begin
      MEASURE_TRIG <= 1'b0;
    end
  end

  // ========================================================================
  // Rate dividers on the measure trigger
  cpm_rate_div u_supply_div (
    .clk  (SYS_CLK),
    .rst  (SYS_RST),
    .trig (MEASURE_TRIG),
    .code (cfg.supply_measure_rate),
    .go   (SUPPLY_MEAS_GO)
  );

  cpm_rate_div u_calib_div (
    .clk  (SYS_CLK),
    .rst  (SYS_RST),
    .trig (MEASURE_TRIG),
    .code (cfg.fast_clock_calib_rate),
    .go   (calib_div)
  );

  // ========================================================================
  // Static outputs
  // Effective frequency bit depends on operating mode
  assign eff_sel = FLOW_MODE ? cfg.fast_clock_freq_select : RC_FAST_CLK_SEL;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      MAINS_60HZ      <= 1'b0;
      MAINS_PERIOD_US <= 15'(`CPM_T50_US);
      LOW_BAT_TH      <= 6'h00;
      FAST_CLK_8MHZ   <= 1'b1;
      TS_UPDATE       <= 1'b0;
    end else begin
      MAINS_60HZ      <= cfg.mains_base_freq_select;
      MAINS_PERIOD_US <= cfg.mains_base_freq_select ? 15'(`CPM_T60_US)
                                                    : 15'(`CPM_T50_US);
      LOW_BAT_TH      <= cfg.low_battery_threshold;
      FAST_CLK_8MHZ   <= eff_sel;
      TS_UPDATE       <= cfg.timestamp_update_mode ? (ms_tick && sec_cnt == S_LAST)
                                                   : ts_sw;
    end
  end

  // ========================================================================
  // Fast clock control
  // High baud hold, restarted by each request, counted in ms
  assign hold_live = (hold_cnt != 7'h00);
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !SERIAL_HIGH_RATE_MODE) begin
      hold_cnt <= 7'h00;
    end else if (FAST_CLK_REQ) begin
      hold_cnt <= hold_ms(cfg.fast_clock_hold_timeout);
    end else if (ms_tick && hold_live) begin
      hold_cnt <= hold_cnt - 7'h01;
    end
  end

  // Pending work; a new request wins over the clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      calib_pend <= 1'b0;
      gph_pend   <= 1'b0;
      CALIB_GO   <= 1'b0;
      GPH_GO     <= 1'b0;
    end else begin
      calib_pend <= calib_div | (calib_pend & ~(fc_state == CPM_FC_ON));
      gph_pend   <= (GPH_REQ & cfg.general_handling_clock_mode) |
                    (gph_pend & ~(fc_state == CPM_FC_ON));
      CALIB_GO   <= calib_pend & (fc_state == CPM_FC_ON);
      GPH_GO     <= (GPH_REQ & ~cfg.general_handling_clock_mode) |
                    (gph_pend & (fc_state == CPM_FC_ON));
    end
  end

  assign fc_req = FAST_CLK_REQ | calib_pend | gph_pend | hold_live;

  // Next state; settle count reaching one hands over to ON
  always_comb begin
    case (fc_state)
      CPM_FC_OFF:    next_fc = fc_req ? CPM_FC_SETTLE : CPM_FC_OFF;
      CPM_FC_SETTLE: next_fc = (settle_cnt <= 16'h0001) ? CPM_FC_ON : CPM_FC_SETTLE;
      CPM_FC_ON:     next_fc = fc_req ? CPM_FC_ON : CPM_FC_OFF;
      default:       next_fc = CPM_FC_OFF;
    endcase
  end

  // State, settle counter and registered outputs
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      fc_state       <= CPM_FC_OFF;
      settle_cnt     <= 16'h0000;
      settle_len     <= 16'h0000;
      FAST_CLK_EN    <= 1'b0;
      FAST_CLK_READY <= 1'b0;
    end else begin
      fc_state       <= next_fc;
      FAST_CLK_EN    <= (next_fc != CPM_FC_OFF);
      FAST_CLK_READY <= (next_fc == CPM_FC_ON);
      if (fc_state == CPM_FC_OFF) begin
        settle_cnt <= settle_cyc(cfg.fast_clock_settle_time);
        settle_len <= settle_cyc(cfg.fast_clock_settle_time);
      end else if (fc_state == CPM_FC_SETTLE) begin
        settle_cnt <= settle_cnt - 16'h0001;
      end
    end
  end

  // ========================================================================
  // Checks
  // Helper: cycles spent settling
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || fc_state != CPM_FC_SETTLE) begin
      chk_cnt <= (fc_state == CPM_FC_SETTLE) ? 16'h0001 : 16'h0000;
    end else begin
      chk_cnt <= chk_cnt + 16'h0001;
    end
  end

  bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("bus answer timing wrong");
  mains_period_a: assert property (##1 MAINS_PERIOD_US == ($past(cfg.mains_base_freq_select)
    ? 15'(`CPM_T60_US) : 15'(`CPM_T50_US))) else $error("base period wrong");
  ts_manual_a: assert property (TS_UPDATE && !$past(cfg.timestamp_update_mode)
    |-> $past(ts_sw)) else $error("timestamp without trigger");
  low_bat_a: assert property (wr_en && AVS_ADDRESS == `CPM_OFS_CFG && AVS_BYTEENABLE[2]
    |=> ##1 LOW_BAT_TH == $past(AVS_WRITEDATA[21:16], 2)) else $error("threshold lost");
  gph_direct_a: assert property (GPH_REQ && !cfg.general_handling_clock_mode
    |=> GPH_GO) else $error("handling delayed");
  gph_fast_a: assert property (GPH_GO && $past(gph_pend)
    |-> $past(fc_state) == CPM_FC_ON) else $error("handling before clock");
  freq_sel_a: assert property (##1 FAST_CLK_8MHZ == $past(FLOW_MODE ?
    cfg.fast_clock_freq_select : RC_FAST_CLK_SEL)) else $error("bad freq bit");
  hold_on_a: assert property (hold_live |=> FAST_CLK_EN)
    else $error("clock off during hold");
  hold_off_a: assert property (!SERIAL_HIGH_RATE_MODE |=> !hold_live)
    else $error("hold without high rate");
  settle_a: assert property ($rose(FAST_CLK_READY) |-> chk_cnt == settle_len)
    else $error("settling time wrong");
  mrg_off_a: assert property (period == '0 |=> !MEASURE_TRIG)
    else $error("trigger while disabled");
  reserved_a: assert property (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == `CPM_OFS_CFG
    |=> AVS_READDATA[31:24] == 8'h00 && AVS_READDATA[1:0] == 2'h0)
    else $error("unused bits not zero");

  ready_c: cover property ($rose(FAST_CLK_READY));
  ts_c: cover property (TS_UPDATE);
  calib_c: cover property (CALIB_GO);
  supply_c: cover property (SUPPLY_MEAS_GO);
endmodule

// file: test_cpm_top.sv
// Self-checking bench for the clock and power configuration block.
// Assumes cpm_pkg and cpm_top are compiled ahead of it; counts are shortened.
`timescale 1ns/1ps
module test_cpm_top
  import cpm_pkg::*;
;
  // ========================================================================
  // Signals
  logic        clk, rst, rd_en, wr_en, flow, rc_sel, lp, hbaud, fc_req, gph_req;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata, q;
  logic        wreq, mains60, ts, trig, sup, cal, gph_go, fc_en, fc_rdy, fc8;
  logic [14:0] period_us;
  logic [5:0]  lbt;
  cpm_cfg_t    cfg;
  int          failures, checked, n_trig, n_sup, n_cal, n_ts, n_gph;
  int          cyc, last_trig, gap, n, s0, c0, g0, t0;
  // Divisor 101 for code 0 gives no pulse in a 100-trigger window
  int          div [8] = '{101, 1, 2, 5, 10, 20, 50, 100};

  // Clock of 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Short ms tick and settle count keep the run brief
  cpm_top #(.MS_CYCLES(10), .LP_TICK_UNITS(620), .SETTLE_LONG_CYC(100)) u_dut (
    .SYS_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .FLOW_MODE(flow),
    .RC_FAST_CLK_SEL(rc_sel), .LP_MODE(lp), .SERIAL_HIGH_RATE_MODE(hbaud),
    .FAST_CLK_REQ(fc_req), .GPH_REQ(gph_req), .MAINS_60HZ(mains60),
    .MAINS_PERIOD_US(period_us), .TS_UPDATE(ts), .LOW_BAT_TH(lbt),
    .MEASURE_TRIG(trig), .SUPPLY_MEAS_GO(sup), .CALIB_GO(cal), .GPH_GO(gph_go),
    .FAST_CLK_EN(fc_en), .FAST_CLK_READY(fc_rdy), .FAST_CLK_8MHZ(fc8));

  // Pulse counters and trigger spacing; held still in reset so X never lands
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst) begin
      n_trig <= n_trig + (trig === 1'b1);
      n_sup <= n_sup + (sup === 1'b1);
      n_cal <= n_cal + (cal === 1'b1);
      n_ts <= n_ts + (ts === 1'b1);
      n_gph <= n_gph + (gph_go === 1'b1);
      if (trig === 1'b1) begin
        gap <= cyc - last_trig;
        last_trig <= cyc;
      end
    end
  end

  // ========================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic expire();
    failures++;
    $display("BAD %0t wait ran out", $time);
    conclude();
  endtask

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd_en <= !w;
    wr_en <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (k >= 50)
      expire();
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Edges until s shows v, left in n
  task automatic waitv(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v) begin
      @(posedge clk);
      n++;
      if (n > lim)
        expire();
    end
  endtask

  task automatic wait_trigs(input int k);
    int t, w;
    t = n_trig + k;
    w = 0;
    while (n_trig < t) begin
      @(posedge clk);
      w++;
      if (w > 5000)
        expire();
    end
  endtask

  // ========================================================================
  // Sequence
  initial begin
    {rst, rd_en, wr_en, flow, rc_sel, lp, hbaud, fc_req, gph_req} = 9'h120;
    addr = 4'h0;
    be = 4'hF;
    wdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    check(q, 32'h0000_0138);
    check(period_us, 15'h4E20);
    tick(60);
    check(n_trig, 32'h0);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF);
    bus(1'b0, 4'h0, 32'h0);
    check(q, 32'h00FF_FFFC);
    check(mains60, 1'h1);
    check(period_us, 15'h4114);
    check(lbt, 6'h3F);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0);
    check(q, 32'h0);
    cfg = '0;
    bus(1'b1, 4'h0, cfg);
    tick(2);
    check(lbt, 6'h0);
    check(period_us, 15'h4E20);
    check(fc8, 1'h0);
    flow <= 1'b0;
    rc_sel <= 1'b1;
    tick(2);
    check(fc8, 1'h1);
    flow <= 1'b1;
    tick(2);
    check(fc8, 1'h0);
    // Software timestamp trigger; its bit reads back as zero
    t0 = n_ts;
    bus(1'b1, 4'h8, 32'h8000_0001);
    tick(3);
    check(n_ts - t0, 32'h1);
    bus(1'b0, 4'h8, 32'h0);
    check(q, 32'h1);
    tick(30);
    check(gap, 32'hA);
    lp <= 1'b1;
    bus(1'b1, 4'h8, 32'h40);
    wait_trigs(2);
    check(gap >= 619 && gap <= 621, 1'h1);
    lp <= 1'b0;
    bus(1'b1, 4'h8, 32'h1);
    // Fast clock kept on so calibration is never held back by settling
    bus(1'b1, 4'h0, cfg);
    fc_req <= 1'b1;
    waitv(fc_en, 1'b1, 10);
    waitv(fc_rdy, 1'b1, 2000);
    check(n >= 739 && n <= 741, 1'h1);
    bus(1'b0, 4'h4, 32'h0);
    check(q, 32'h3);
    t0 = n_ts;
    for (int c = 0; c < 8; c++) begin
      cfg.supply_measure_rate = 3'(c);
      cfg.fast_clock_calib_rate = 3'(c);
      bus(1'b1, 4'h0, cfg);
      wait_trigs(1);
      tick(5);
      s0 = n_sup;
      c0 = n_cal;
      wait_trigs(100);
      tick(5);
      check(n_sup - s0, 100 / div[c]);
      check(n_cal - c0, 100 / div[c]);
    end
    check(n_ts - t0, 32'h0);
    // Hold after the last request, shortest and longest codes
    fc_req <= 1'b0;
    hbaud <= 1'b1;
    cfg.supply_measure_rate = 3'h0;
    cfg.fast_clock_calib_rate = 3'h0;
    for (int h = 0; h < 2; h++) begin
      cfg.fast_clock_hold_timeout = h ? 3'h7 : 3'h0;
      bus(1'b1, 4'h0, cfg);
      // Settling is never cut short, so hold the request until ready
      fc_req <= 1'b1;
      waitv(fc_rdy, 1'b1, 2000);
      bus(1'b0, 4'h4, 32'h0);
      check(q, 32'hB);
      fc_req <= 1'b0;
      waitv(fc_en, 1'b0, 3000);
      check(n >= (h ? 1188 : 88) && n <= (h ? 1204 : 104), 1'h1);
    end
    hbaud <= 1'b0;
    fc_req <= 1'b1;
    waitv(fc_rdy, 1'b1, 2000);
    bus(1'b0, 4'h4, 32'h0);
    check(q, 32'h3);
    fc_req <= 1'b0;
    waitv(fc_en, 1'b0, 50);
    check(n <= 4, 1'h1);
    // General handling without, then with, the fast clock
    g0 = n_gph;
    gph_req <= 1'b1;
    tick(1);
    gph_req <= 1'b0;
    tick(3);
    check(n_gph - g0, 32'h1);
    check(fc_en, 1'h0);
    cfg.general_handling_clock_mode = 1'b1;
    cfg.fast_clock_settle_time = 3'h7;
    bus(1'b1, 4'h0, cfg);
    g0 = n_gph;
    gph_req <= 1'b1;
    tick(1);
    gph_req <= 1'b0;
    waitv(fc_en, 1'b1, 10);
    waitv(fc_rdy, 1'b1, 500);
    check(n >= 99 && n <= 101, 1'h1);
    check(n_gph - g0, 32'h0);
    tick(3);
    check(n_gph - g0, 32'h1);
    // Automatic refresh once a second
    cfg.timestamp_update_mode = 1'b1;
    bus(1'b1, 4'h0, cfg);
    tick(2);
    t0 = n_ts;
    tick(10000);
    check(n_ts - t0, 32'h1);
    conclude();
  end
endmodule
